// [logic/lfs_params.svh]
`ifndef LFS_PARAMS_SVH
`define LFS_PARAMS_SVH
// ==========================================
// geometry
`define LFS_CH          24
`define LFS_SR_W        25
`define LFS_DSEL_HI     23
`define LFS_DSEL_LO     21
`define LFS_DSEL_SHORT  3'h4
// ==========================================
// register byte offsets
`define LFS_OFF_ONOFF   12'h000
`define LFS_OFF_CTRL    12'h004
`define LFS_OFF_SHIFT   12'h008
`define LFS_OFF_STATUS  12'h00c
`define LFS_OFF_FAULT   12'h010
// ==========================================
// status register bit positions
`define LFS_ST_CUTOFF   0
`define LFS_ST_THOLD    1
`define LFS_ST_BLANK    2
// ==========================================
// reset values
`define LFS_RST_ONOFF   24'h000000
`define LFS_RST_CTRL    24'h000000
`define LFS_RST_SHIFT   25'h0000000
// ==========================================
// timing
`define LFS_CLK_NS      50
`define LFS_SETTLE_NS   1000
`define LFS_SETTLE_CYC  ((`LFS_SETTLE_NS + `LFS_CLK_NS - 1) / `LFS_CLK_NS)
`define LFS_STAGGER_NS  100
`define LFS_STAGGER_CYC ((`LFS_STAGGER_NS + `LFS_CLK_NS - 1) / `LFS_CLK_NS)
`endif

// [logic/lfs_pkg.sv]
package lfs_pkg;
  typedef enum logic { LFS_OPEN, LFS_SHORT } lfs_detect_t;
  typedef enum logic { LFS_IDLE, LFS_WALK } lfs_walk_t;
endpackage : lfs_pkg

// [logic/lfs_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module lfs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q_ff
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      q_ff    <= '0;
    end else begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end
endmodule : lfs_sync
`default_nettype wire

// [logic/lfs_stagger.sv]
`timescale 1ns/1ns
`default_nettype none
module lfs_stagger #(
  parameter int CH   = 24,
  parameter int STEP = 2
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          start,
  input  wire logic [CH-1:0] target,
  output logic      [CH-1:0] en_ff
);
  localparam int IW = $clog2(CH);
  localparam int CW = $clog2(STEP + 1);
  localparam logic [IW-1:0] LAST = IW'(CH - 1);
  localparam logic [CW-1:0] STOP = CW'(STEP - 1);

  lfs_pkg::lfs_walk_t state_ff;
  logic [IW-1:0]      idx_ff;
  logic [CW-1:0]      cnt_ff;
  logic               step;

  assign step = (state_ff == lfs_pkg::LFS_WALK) && (cnt_ff == STOP);

  // ==========================================
  // walk through channels in fixed order, one per step
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= lfs_pkg::LFS_IDLE;
      idx_ff   <= '0;
      cnt_ff   <= '0;
    end else if (start) begin
      state_ff <= lfs_pkg::LFS_WALK;
      idx_ff   <= '0;
      cnt_ff   <= '0;
    end else begin
      unique case (state_ff)
        lfs_pkg::LFS_IDLE: begin
          cnt_ff <= '0;
        end
        lfs_pkg::LFS_WALK: begin
          if (step) begin
            cnt_ff <= '0;
            idx_ff <= idx_ff + 1'b1;
            if (idx_ff == LAST) begin
              state_ff <= lfs_pkg::LFS_IDLE;
            end
          end else begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
      endcase
    end
  end

  // on and off both take the staggered path
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_ff <= '0;
    end else if (step) begin
      en_ff[idx_ff] <= target[idx_ff];
    end
  end
endmodule : lfs_stagger
`default_nettype wire

// [logic/lfs_fault_capture.sv]
// Operation
// - detect-select codes 0..3 pick open checking, 4..7 pick short checking
// - open mode: flag is 1 when sink voltage at or below threshold
// - short mode: flag is 1 when sink voltage above threshold
// - flag reads 0 for any output whose on/off bit is 0
// - blanking rising edge captures detection results into fault holder
// - blanking low: holder follows results, changes valid after 1 us
// - latch strobe rising edge copies holder into common shift register
// - over-temperature forces outputs off; fault results are invalid
// - over-temperature sets flag and turns off every current sink
// - outputs restart on their own once temperature falls below release
// - over-temperature flag kept in its own holder until latch strobe
// - at latch strobe thermal holder clears if below release, else stays
// - outputs switch in order red0, green0, blue0 ... blue7 with delay
// - staggered order applies to turn-off as well as turn-on
// - detect-select code sits in bits 23..21 of control data
// - status overwrites shift register only when its top bit is 0
// - status shifts out serially, one bit per shift clock rising edge
// - on/off bit 0 turns its sink off, 1 turns it on
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "lfs_params.svh"
module lfs_fault_capture #(
  parameter int CH          = `LFS_CH,
  parameter int SETTLE_CYC  = `LFS_SETTLE_CYC,
  parameter int STAGGER_CYC = `LFS_STAGGER_CYC
) (
  input  wire logic          SYS_CLK,
  input  wire logic          RST,
  input  wire logic          PSEL,
  input  wire logic          PENABLE,
  input  wire logic          PWRITE,
  input  wire logic [11:0]   PADDR,
  input  wire logic [31:0]   PWDATA,
  output logic      [31:0]   PRDATA,
  output logic               PREADY,
  output logic               PSLVERR,
  input  wire logic          BLANK,
  input  wire logic          LATCH_STROBE,
  input  wire logic          SHIFT_CLK,
  input  wire logic          SERIAL_IN,
  input  wire logic [CH-1:0] SINK_ABOVE,
  input  wire logic          TEMP_OVER,
  input  wire logic          TEMP_RELEASED,
  output logic      [CH-1:0] CURRENT_SINK_OUTPUTS,
  output logic               SERIAL_STATUS_OUT,
  output logic               OVERTEMP_FLAG
);
  localparam int SW = $clog2(SETTLE_CYC + 1);
  localparam logic [SW-1:0] SETTLE_MAX = SW'(SETTLE_CYC);
  localparam int NS = CH + 6;

  // ==========================================
  // input synchronisers
  logic [NS-1:0]   sync_q;
  logic            blank_n_s;
  logic            blank_s;
  logic            latch_s;
  logic            sclk_s;
  logic            sin_s;
  logic            tover_s;
  logic            trel_s;
  logic [CH-1:0]   above_s;
  logic            blank_d_ff;
  logic            latch_d_ff;
  logic            sclk_d_ff;
  logic            blank_rise;
  logic            blank_fall;
  logic            latch_rise;
  logic            sclk_rise;

  lfs_sync #(.W(NS)) u_sync (
    .clk  (SYS_CLK),
    .rst  (RST),
    .d    ({~BLANK, LATCH_STROBE, SHIFT_CLK, SERIAL_IN, TEMP_OVER, TEMP_RELEASED,
            SINK_ABOVE}),
    .q_ff (sync_q)
  );

  // blanking goes through inverted so the synchroniser's reset matches the idle-high pin
  assign {blank_n_s, latch_s, sclk_s, sin_s, tover_s, trel_s, above_s} = sync_q;
  assign blank_s = ~blank_n_s;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      blank_d_ff <= 1'b1;
      latch_d_ff <= 1'b0;
      sclk_d_ff  <= 1'b0;
    end else begin
      blank_d_ff <= blank_s;
      latch_d_ff <= latch_s;
      sclk_d_ff  <= sclk_s;
    end
  end

  assign blank_rise = blank_s & ~blank_d_ff;
  assign blank_fall = ~blank_s & blank_d_ff;
  assign latch_rise = latch_s & ~latch_d_ff;
  assign sclk_rise  = sclk_s & ~sclk_d_ff;

  // ==========================================
  // apb slave
  logic [CH-1:0]         onoff_ff;
  logic [CH-1:0]         ctrl_ff;
  logic [`LFS_SR_W-1:0]  shift_ff;
  logic [CH-1:0]         hold_ff;
  logic                  thold_ff;
  logic                  cutoff_ff;
  logic                  pready_ff;
  logic [31:0]           prdata_ff;
  logic                  pslverr_ff;
  logic [31:0]           nxt_prdata;
  logic                  nxt_err;
  logic                  wr_en;

  assign wr_en = PSEL & PENABLE & PWRITE & pready_ff;

  always_comb begin
    nxt_prdata = 32'h00000000;
    nxt_err    = 1'b0;
    unique case (PADDR)
      `LFS_OFF_ONOFF:  nxt_prdata = {8'h00, onoff_ff};
      `LFS_OFF_CTRL:   nxt_prdata = {8'h00, ctrl_ff};
      `LFS_OFF_SHIFT:  nxt_prdata = {7'h00, shift_ff};
      `LFS_OFF_FAULT:  nxt_prdata = {8'h00, hold_ff};
      `LFS_OFF_STATUS: begin
        nxt_prdata[`LFS_ST_CUTOFF] = cutoff_ff;
        nxt_prdata[`LFS_ST_THOLD]  = thold_ff;
        nxt_prdata[`LFS_ST_BLANK]  = blank_s;
      end
      default:         nxt_err = 1'b1;
    endcase
  end

  // answer one cycle after setup: access phase always sees pready
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= PSEL & ~PENABLE;
      prdata_ff  <= (PSEL & ~PENABLE) ? nxt_prdata : 32'h00000000;
      pslverr_ff <= PSEL & ~PENABLE & nxt_err;
    end
  end

  assign PRDATA  = prdata_ff;
  assign PREADY  = pready_ff;
  assign PSLVERR = pslverr_ff;

  // ==========================================
  // data latches and common shift register
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      onoff_ff <= `LFS_RST_ONOFF;
    end else if (latch_rise && !shift_ff[`LFS_SR_W-1]) begin
      onoff_ff <= shift_ff[CH-1:0];
    end else if (wr_en && PADDR == `LFS_OFF_ONOFF) begin
      onoff_ff <= PWDATA[CH-1:0];
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ctrl_ff <= `LFS_RST_CTRL;
    end else if (latch_rise && shift_ff[`LFS_SR_W-1]) begin
      ctrl_ff <= shift_ff[CH-1:0];
    end else if (wr_en && PADDR == `LFS_OFF_CTRL) begin
      ctrl_ff <= PWDATA[CH-1:0];
    end
  end

  // latch strobe beats a shift in the same cycle
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      shift_ff <= `LFS_RST_SHIFT;
    end else if (latch_rise) begin
      if (!shift_ff[`LFS_SR_W-1]) begin
        shift_ff <= {thold_ff, hold_ff};
      end
    end else if (sclk_rise) begin
      shift_ff <= {shift_ff[`LFS_SR_W-2:0], sin_s};
    end else if (wr_en && PADDR == `LFS_OFF_SHIFT) begin
      shift_ff <= PWDATA[`LFS_SR_W-1:0];
    end
  end

  assign SERIAL_STATUS_OUT = shift_ff[`LFS_SR_W-1];

  // ==========================================
  // fault detection
  lfs_pkg::lfs_detect_t mode;
  logic [CH-1:0]        live_flags;
  logic [CH-1:0]        live_q_ff;
  logic [SW-1:0]        settle_ff;
  logic                 settled;

  assign mode = (ctrl_ff[`LFS_DSEL_HI:`LFS_DSEL_LO] >= `LFS_DSEL_SHORT) ?
                lfs_pkg::LFS_SHORT : lfs_pkg::LFS_OPEN;

  for (genvar g = 0; g < CH; g++) begin : g_flag
    assign live_flags[g] = onoff_ff[g] & ~cutoff_ff &
                           ((mode == lfs_pkg::LFS_SHORT) ? above_s[g]
                                                         : ~above_s[g]);
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      live_q_ff <= '0;
      settle_ff <= '0;
    end else begin
      live_q_ff <= live_flags;
      if (live_flags != live_q_ff) begin
        settle_ff <= '0;
      end else if (settle_ff != SETTLE_MAX) begin
        settle_ff <= settle_ff + 1'b1;
      end
    end
  end

  assign settled = (settle_ff == SETTLE_MAX);

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      hold_ff <= '0;
    end else if (blank_rise) begin
      hold_ff <= live_flags;
    end else if (!blank_s && settled) begin
      hold_ff <= live_flags;
    end
  end

  // ==========================================
  // thermal protection
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      cutoff_ff <= 1'b0;
    end else if (tover_s) begin
      cutoff_ff <= 1'b1;
    end else if (trel_s) begin
      cutoff_ff <= 1'b0;
    end
  end

  // a new over-temperature wins over the clear at the strobe
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      thold_ff <= 1'b0;
    end else if (tover_s) begin
      thold_ff <= 1'b1;
    end else if (latch_rise && trel_s) begin
      thold_ff <= 1'b0;
    end
  end

  assign OVERTEMP_FLAG = thold_ff;

  // ==========================================
  // staggered output switching
  logic [CH-1:0] stag_en;
  logic [CH-1:0] sink_ff;

  lfs_stagger #(.CH(CH), .STEP(STAGGER_CYC)) u_stagger (
    .clk    (SYS_CLK),
    .rst    (RST),
    .start  (blank_fall | blank_rise | latch_rise),
    .target (onoff_ff & {CH{~blank_s}}),
    .en_ff  (stag_en)
  );

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      sink_ff <= '0;
    end else begin
      sink_ff <= stag_en & {CH{~cutoff_ff}};
    end
  end

  assign CURRENT_SINK_OUTPUTS = sink_ff;

  // ==========================================
  // assertions
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  short_mask_a: assert property (
    mode == lfs_pkg::LFS_SHORT |-> (live_flags & ~above_s) == '0)
    else $error("short mode reported a low sink");
  open_flag_a: assert property (
    mode == lfs_pkg::LFS_OPEN && !cutoff_ff |-> live_flags == (onoff_ff & ~above_s))
    else $error("open flag mismatch");
  short_flag_a: assert property (
    mode == lfs_pkg::LFS_SHORT && !cutoff_ff |-> live_flags == (onoff_ff & above_s))
    else $error("short flag mismatch");
  off_zero_a: assert property ((live_flags & ~onoff_ff) == '0)
    else $error("flag set on an off output");
  blank_capture_a: assert property (
    blank_rise |=> hold_ff == $past(live_flags))
    else $error("holder missed blanking capture");
  settle_follow_a: assert property (
    !blank_s && settled && !blank_rise |=> hold_ff == $past(live_flags))
    else $error("holder did not follow settled result");
  latch_status_a: assert property (
    latch_rise && !shift_ff[`LFS_SR_W-1] |=> shift_ff == $past({thold_ff, hold_ff}))
    else $error("status not loaded at strobe");
  cutoff_invalid_a: assert property (cutoff_ff |-> live_flags == '0)
    else $error("fault flag during cutoff");
  cutoff_off_a: assert property (
    tover_s |=> ##1 CURRENT_SINK_OUTPUTS == '0)
    else $error("sinks on during cutoff");
  auto_restart_a: assert property (
    cutoff_ff && trel_s && !tover_s |=> !cutoff_ff)
    else $error("cutoff did not release");
  thold_clear_a: assert property (
    latch_rise && trel_s && !tover_s |=> !thold_ff)
    else $error("thermal holder not cleared");
  ctrl_keep_a: assert property (
    latch_rise && shift_ff[`LFS_SR_W-1] |=> ctrl_ff == $past(shift_ff[CH-1:0])
      && shift_ff == $past(shift_ff))
    else $error("status copied with top bit set");
  shift_bit_a: assert property (
    sclk_rise && !latch_rise |=> SERIAL_STATUS_OUT == $past(shift_ff[`LFS_SR_W-2]))
    else $error("serial shift wrong");

  blank_fault_c: cover property (blank_rise && live_flags != '0);
  status_load_c: cover property (latch_rise && !shift_ff[`LFS_SR_W-1] && thold_ff);
  cutoff_cycle_c: cover property (cutoff_ff ##[1:300] !cutoff_ff);
endmodule : lfs_fault_capture
`default_nettype wire

// [testbench/lfs_ctrl_model.sv]
`timescale 1ns/1ns
`default_nettype none
module lfs_ctrl_model (
  input  wire logic clk,
  input  wire logic serial_status_out,
  output logic      blank,
  output logic      latch_strobe,
  output logic      shift_clk,
  output logic      serial_in
);
  int low_cnt = 0;
  initial begin
    blank = 1'b1;
    latch_strobe = 1'b0;
    shift_clk = 1'b0;
    serial_in = 1'b0;
  end
  // ==========================================
  // blanking and strobe
  always @(posedge clk) low_cnt <= blank ? 0 : low_cnt + 1;
  task automatic set_blank(input logic v);
    // results need time to settle before blanking may rise again
    while (v && low_cnt < 24) @(posedge clk);
    @(posedge clk) blank <= v;
  endtask : set_blank
  task automatic pulse_latch();
    @(posedge clk) latch_strobe <= 1'b1;
    repeat (4) @(posedge clk);
    latch_strobe <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : pulse_latch
  // ==========================================
  // serial word, msb first, 400 ns shift clock
  task automatic shift_word(input logic [24:0] din, output logic [24:0] dout);
    for (int i = 24; i >= 0; i--) begin
      @(posedge clk) serial_in <= din[i];
      repeat (2) @(posedge clk);
      @(negedge clk) dout[i] = serial_status_out;
      @(posedge clk) shift_clk <= 1'b1;
      repeat (4) @(posedge clk);
      shift_clk <= 1'b0;
    end
    // no pull on the data line: leave it at the inverse once idle
    serial_in <= ~din[0];
  endtask : shift_word
endmodule : lfs_ctrl_model
`default_nettype wire

// [testbench/tb_led_fault_status_capture.sv]
`timescale 1ns/1ns
`default_nettype none
`include "lfs_params.svh"
module tb_led_fault_status_capture;
  localparam int STG = `LFS_STAGGER_CYC;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        blank, latch_s, shift_clk, ser_in, ser_out, temp_over, temp_rel, ot_flag, er;
  logic [23:0] sink_above, sinks, on, above, fexp;
  logic [23:0] prev = '0;
  logic [20:0] br;
  logic [24:0] sw;
  int          seed = 32'he664a04f;
  int          fails = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          t_chg [24];

  lfs_fault_capture u_lfs_fault_capture (
    .SYS_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .BLANK(blank), .LATCH_STROBE(latch_s), .SHIFT_CLK(shift_clk), .SERIAL_IN(ser_in),
    .SINK_ABOVE(sink_above), .TEMP_OVER(temp_over), .TEMP_RELEASED(temp_rel),
    .CURRENT_SINK_OUTPUTS(sinks), .SERIAL_STATUS_OUT(ser_out), .OVERTEMP_FLAG(ot_flag));

  lfs_ctrl_model u_lfs_ctrl_model (
    .clk(clk), .serial_status_out(ser_out), .blank(blank), .latch_strobe(latch_s),
    .shift_clk(shift_clk), .serial_in(ser_in));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ==========================================
  // sink change times for the stagger order
  always @(posedge clk) begin
    cyc <= cyc + 1;
    prev <= sinks;
    for (int i = 0; i < 24; i++)
      if (sinks[i] !== prev[i]) t_chg[i] <= cyc;
  end

  // ==========================================
  // helpers
  function automatic logic [23:0] exp_fault(input logic [2:0] ds, input logic [23:0] o,
                                            input logic [23:0] ab);
    return o & ((ds >= `LFS_DSEL_SHORT) ? ab : ~ab);
  endfunction : exp_fault

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_val

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    // request stands until pready is seen high at a rising edge
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic load(input logic top, input logic [23:0] w);
    apb(1'b1, `LFS_OFF_SHIFT, {7'h00, top, w});
    u_lfs_ctrl_model.pulse_latch();
  endtask : load

  task automatic chk_order();
    for (int i = 1; i < 24; i++)
      chk_val("stagger_gap", STG, t_chg[i] - t_chg[i-1]);
  endtask : chk_order

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    report_and_stop();
  end

  // ==========================================
  // main sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    sink_above = '0;
    temp_over = 1'b0;
    temp_rel = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      apb(1'b0, 12'(k * 4), 32'h0);
      chk_val("reset_value", (k == 3) ? 32'h4 : 32'h0, rd);
    end
    apb(1'b0, 12'h014, 32'h0);
    chk_val("unmapped_err", 32'h1, {31'h0, er});
    for (int d = 0; d < 8; d++) begin
      on = (d == 0) ? 24'hffffff : (d == 7) ? 24'h000000 : 24'($random(seed));
      above = 24'($random(seed));
      br = 21'($random(seed));
      sink_above <= above;
      load(1'b1, {3'(d), br});
      apb(1'b0, `LFS_OFF_SHIFT, 32'h0);
      chk_val("shift_kept", {7'h00, 1'b1, 3'(d), br}, rd);
      load(1'b0, on);
      u_lfs_ctrl_model.set_blank(1'b0);
      repeat (60) @(posedge clk);
      chk_val("sinks_on", {8'h00, on}, {8'h00, sinks});
      u_lfs_ctrl_model.set_blank(1'b1);
      repeat (60) @(posedge clk);
      chk_val("sinks_blank", 32'h0, {8'h00, sinks});
      fexp = exp_fault(3'(d), on, above);
      apb(1'b0, `LFS_OFF_FAULT, 32'h0);
      chk_val("fault", {8'h00, fexp}, rd);
      apb(1'b0, `LFS_OFF_CTRL, 32'h0);
      chk_val("ctrl", {8'h00, 3'(d), br}, rd);
      load(1'b0, on);
      apb(1'b0, `LFS_OFF_SHIFT, 32'h0);
      chk_val("status_load", {8'h00, fexp}, rd);
      u_lfs_ctrl_model.shift_word({1'b0, on}, sw);
      chk_val("serial_out", {8'h00, fexp}, {7'h00, sw});
    end
    load(1'b0, 24'hffffff);
    u_lfs_ctrl_model.set_blank(1'b0);
    repeat (60) @(posedge clk);
    chk_order();
    u_lfs_ctrl_model.set_blank(1'b1);
    repeat (60) @(posedge clk);
    chk_order();
    u_lfs_ctrl_model.set_blank(1'b0);
    repeat (60) @(posedge clk);
    temp_over <= 1'b1;
    repeat (40) @(posedge clk);
    chk_val("sinks_hot", 32'h0, {8'h00, sinks});
    chk_val("flag_hot", 32'h1, {31'h0, ot_flag});
    apb(1'b0, `LFS_OFF_FAULT, 32'h0);
    chk_val("fault_hot", 32'h0, rd);
    apb(1'b0, `LFS_OFF_STATUS, 32'h0);
    chk_val("status_hot", 32'h3, rd & 32'h7);
    temp_over <= 1'b0;
    load(1'b0, 24'hffffff);
    chk_val("flag_stays", 32'h1, {31'h0, ot_flag});
    temp_rel <= 1'b1;
    repeat (80) @(posedge clk);
    chk_val("sinks_back", 32'hffffff, {8'h00, sinks});
    chk_val("flag_held", 32'h1, {31'h0, ot_flag});
    load(1'b0, 24'hffffff);
    chk_val("flag_clear", 32'h0, {31'h0, ot_flag});
    report_and_stop();
  end
endmodule : tb_led_fault_status_capture
`default_nettype wire
